// file: verilog/sar_converter_control.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module sar_converter_control (
   // system
   input  wire logic        CLOCK_I,
   input  wire logic        RESET_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output var  logic [31:0] PRDATA_O,
   output var  logic        PREADY_O,
   output var  logic        PSLVERR_O,
   // clock source pins
   input  wire logic        SUBSYS_CLK_I,
   input  wire logic        MASTER_CLK_I,
   input  wire logic        AUX_CLK_I,
   input  wire logic        OSC_CLK_I,
   // timer trigger pins
   input  wire logic        TIMER_OUT0_I,
   input  wire logic        TIMER_OUT1_I,
   input  wire logic        TIMER_OUT2_I,
   // analog core
   input  wire logic        COMPARE_I,
   output var  logic [9:0]  DAC_CODE_O,
   output var  logic [3:0]  CHANNEL_O,
   output var  logic [7:0]  PIN_ANALOG_EN_O,
   output var  logic        SAMPLE_ACTIVE_O,
   output var  logic        CORE_POWER_O,
   output var  logic        OSC_ENABLE_O,
   // reference control
   output var  logic        BANDGAP_ON_O,
   output var  logic        REF_BUFFER_ON_O,
   output var  logic        REF_LEVEL_O,
   output var  logic        REF_PIN_OUT_O,
   output var  logic        EXT_REF_BUFFER_O,
   output var  logic        BUFFER_SLOW_O
);

   ////////////////////////////////////////////////////////////////
   // declarations

   sar_pkg::ctrl0_type ctrl0;      // power, reference, timing
   sar_pkg::ctrl1_type ctrl1;      // mux, trigger, clock
   sar_pkg::state_type state;      // operation phase
   sar_pkg::state_type next_state; // phase after this edge
   logic [8:0]  raw_in;            // asynchronous pins
   logic [8:0]  s1;                // first sync stage
   logic [8:0]  s2;                // second sync stage
   logic [8:0]  s3;                // third sync stage
   logic [8:0]  filt;              // agreed level
   logic        src_prev;          // source level last cycle
   logic        src_level;         // chosen source level
   logic [2:0]  div_cnt;           // divider position
   logic        conv_tick;         // one conversion clock
   logic        trig_level;        // selected, before polarity flip
   logic        t_s1;              // tick-domain sync 1
   logic        t_s2;              // tick-domain sync 2
   logic        t_prev;            // previous synced trigger
   logic        trig_edge;         // rising trigger seen
   logic [6:0]  phase_cnt;         // ticks in current phase
   logic [9:0]  trial;             // sar working code
   logic [3:0]  bit_idx;           // bit under decision
   logic [9:0]  keep;              // code after decision
   logic [9:0]  conversion_result; // last finished code
   logic        result_new;        // unread result
   logic        setup;             // apb setup phase
   logic        wr;                // write completes
   logic        rd;                // read completes
   logic [31:0] rd_val;            // read mux
   logic        rd_ok;             // address mapped
   logic        next_busy;         // next phase not idle
   logic        start_op;          // idle to sample

   // sample length decode, used by timer and checks
   function automatic logic [6:0] hold_ticks(input logic [1:0] sel);
      unique case (sel)
         2'h0: hold_ticks = sar_pkg::HOLD_SHORT;
         2'h1: hold_ticks = sar_pkg::HOLD_MID;
         2'h2: hold_ticks = sar_pkg::HOLD_LONG;
         2'h3: hold_ticks = sar_pkg::HOLD_MAX;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////
   // pin synchronisers

   assign raw_in = {COMPARE_I, TIMER_OUT2_I, TIMER_OUT0_I,
                    TIMER_OUT1_I, 1'b0, OSC_CLK_I, AUX_CLK_I,
                    MASTER_CLK_I, SUBSYS_CLK_I};

   // three flops; a change counts once stages 2 and 3 agree
   generate
      for (genvar g = 0; g < 9; g++)
      begin : g_sync
         always_ff @(posedge CLOCK_I)
         begin
            if (RESET_I)
            begin
               s1[g]   <= 1'b0;
               s2[g]   <= 1'b0;
               s3[g]   <= 1'b0;
               filt[g] <= 1'b0;
            end
            else
            begin
               s1[g] <= raw_in[g];
               s2[g] <= s1[g];
               s3[g] <= s2[g];
               if (s2[g] == s3[g])
                  filt[g] <= s3[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // conversion clock: source pick and divider

   // slot 4 unused, so sources index slots 0..3 directly
   assign src_level = filt[ctrl1.clock_source_select];

   // sources must stay below a quarter of CLOCK_I to be seen
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         src_prev  <= 1'b0;
         div_cnt   <= 3'h0;
         conv_tick <= 1'b0;
      end
      else
      begin
         src_prev  <= src_level;
         conv_tick <= 1'b0;
         if (src_level && !src_prev)
         begin
            // field n divides by n+1
            if (div_cnt >= ctrl1.clock_divider)
            begin
               div_cnt   <= 3'h0;
               conv_tick <= 1'b1;
            end
            else
               div_cnt <= div_cnt + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // trigger select, invert, resync to ticks

   always_comb
   begin
      unique case (ctrl1.trigger_source_select)
         2'h0: trig_level = ctrl0.software_start;
         2'h1: trig_level = filt[sar_pkg::IN_TIMER1];
         2'h2: trig_level = filt[sar_pkg::IN_TIMER0];
         2'h3: trig_level = filt[sar_pkg::IN_TIMER2];
      endcase
   end

   // polarity flip sits ahead of the edge detector
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         t_s1   <= 1'b0;
         t_s2   <= 1'b0;
         t_prev <= 1'b0;
      end
      else if (conv_tick)
      begin
         t_s1   <= trig_level ^ ctrl1.trigger_invert;
         t_s2   <= t_s1;
         t_prev <= t_s2;
      end
   end

   assign trig_edge = t_s2 && !t_prev;

   ////////////////////////////////////////////////////////////////
   // operation sequencer

   // everything advances on ticks only: a stopped source
   // freezes the operation, nothing is ever completed
   always_comb
   begin
      next_state = state;
      unique case (state)
         sar_pkg::ST_IDLE:
            // edges outside idle are never looked at
            if (conv_tick && trig_edge
                && ctrl0.conversion_enable
                && ctrl0.core_on)
               next_state = sar_pkg::ST_SAMPLE;
         sar_pkg::ST_SAMPLE:
            if (conv_tick && phase_cnt ==
                hold_ticks(ctrl0.sample_hold_time) - 7'h1)
               next_state = sar_pkg::ST_CONVERT;
         sar_pkg::ST_CONVERT:
            if (conv_tick && phase_cnt == sar_pkg::CONV_TICKS - 7'h1)
               next_state = sar_pkg::ST_IDLE;
         default:
            // code 10 is illegal; recover to idle
            next_state = sar_pkg::ST_IDLE;
      endcase
   end

   assign start_op = (state == sar_pkg::ST_IDLE)
                     && (next_state == sar_pkg::ST_SAMPLE);

   // state and tick counter per phase
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         state     <= sar_pkg::ST_IDLE;
         phase_cnt <= 7'h00;
      end
      else
      begin
         state <= next_state;
         if (next_state != state)
            phase_cnt <= 7'h00;
         else if (conv_tick)
            phase_cnt <= phase_cnt + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   // successive approximation

   assign bit_idx = 4'(4'h9 - phase_cnt[3:0]);

   // comparator high keeps the trial bit set
   always_comb
   begin
      keep = trial;
      // idle ticks past bit 0 would index beyond the code
      if (!filt[sar_pkg::IN_COMP] && bit_idx <= 4'h9)
         keep[bit_idx] = 1'b0;
   end

   // comparator resync lag is four cycles; ticks must be wider
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         trial             <= 10'h000;
         conversion_result <= 10'h000;
      end
      else if (state == sar_pkg::ST_SAMPLE
               && next_state == sar_pkg::ST_CONVERT)
         trial <= sar_pkg::SIGN_FLIP;
      else if (state == sar_pkg::ST_CONVERT && conv_tick)
      begin
         if (phase_cnt < sar_pkg::SAR_STEPS)
         begin
            // all-high comparator settles at full scale
            trial <= keep;
            if (bit_idx != 4'h0)
               trial[bit_idx - 4'h1] <= 1'b1;
         end
         if (next_state == sar_pkg::ST_IDLE)
            // msb flip turns offset binary to signed
            conversion_result <= ctrl1.twos_complement
                                 ? (trial ^ sar_pkg::SIGN_FLIP)
                                 : trial;
      end
   end

   assign DAC_CODE_O = trial;

   ////////////////////////////////////////////////////////////////
   // apb slave

   assign setup = PSEL_I && !PENABLE_I;
   assign wr    = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
                  && !PSLVERR_O;
   assign rd    = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;

   // read mux; unmapped answers error with zero data
   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      unique case (PADDR_I)
         sar_pkg::OFF_CTRL0:  rd_val[11:0] = ctrl0;
         sar_pkg::OFF_CTRL1:  rd_val[12:0] = ctrl1;
         sar_pkg::OFF_AEN:    rd_val[7:0]  = PIN_ANALOG_EN_O;
         sar_pkg::OFF_RESULT: rd_val[9:0]  = conversion_result;
         sar_pkg::OFF_STATUS: rd_val[2:0]  = {result_new,
                                  state == sar_pkg::ST_CONVERT,
                                  SAMPLE_ACTIVE_O};
         default:             rd_ok        = 1'b0;
      endcase
   end

   // answer captured in setup, one access cycle, no waits
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h0000_0000;
      end
      else
      begin
         PREADY_O  <= setup;
         PSLVERR_O <= setup && !rd_ok;
         if (setup)
            PRDATA_O <= rd_val;
      end
   end

   ////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         ctrl0 <= sar_pkg::CTRL0_RESET;
         ctrl1 <= sar_pkg::CTRL1_RESET;
      end
      else
      begin
         // start bit self-clears; a same-cycle write wins
         if (start_op)
            ctrl0.software_start <= 1'b0;
         if (wr && PADDR_I == sar_pkg::OFF_CTRL0)
         begin
            // while enabled only enable and start move
            if (!ctrl0.conversion_enable)
               ctrl0 <= PWDATA_I[11:0];
            else
            begin
               ctrl0.conversion_enable <= PWDATA_I[0];
               ctrl0.software_start    <= PWDATA_I[1];
            end
         end
         if (wr && PADDR_I == sar_pkg::OFF_CTRL1
             && !ctrl0.conversion_enable)
         begin
            ctrl1 <= PWDATA_I[12:0];
            // codes above the last input alias to it
            if (PWDATA_I[3:0] > sar_pkg::CHAN_LAST)
               ctrl1.channel <= sar_pkg::CHAN_LAST;
         end
      end
   end

   assign CHANNEL_O     = ctrl1.channel;
   assign REF_LEVEL_O   = ctrl0.reference_level_select;
   assign BUFFER_SLOW_O = ctrl0.buffer_speed_select;

   // pin buffer disables stay writable at any time
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         PIN_ANALOG_EN_O <= sar_pkg::AEN_RESET;
      else if (wr && PADDR_I == sar_pkg::OFF_AEN)
         PIN_ANALOG_EN_O <= PWDATA_I[7:0];
   end

   // unread flag: cleared by reading result, set wins
   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
         result_new <= 1'b0;
      else
      begin
         if (rd && PADDR_I == sar_pkg::OFF_RESULT)
            result_new <= 1'b0;
         if (state == sar_pkg::ST_CONVERT
             && next_state == sar_pkg::ST_IDLE)
            result_new <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // power management, aligned with the state register

   assign next_busy = next_state != sar_pkg::ST_IDLE;

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         SAMPLE_ACTIVE_O  <= 1'b0;
         CORE_POWER_O     <= 1'b0;
         OSC_ENABLE_O     <= 1'b0;
         BANDGAP_ON_O     <= 1'b0;
         REF_BUFFER_ON_O  <= 1'b0;
         REF_PIN_OUT_O    <= 1'b0;
         EXT_REF_BUFFER_O <= 1'b0;
      end
      else
      begin
         SAMPLE_ACTIVE_O <= next_state == sar_pkg::ST_SAMPLE;
         CORE_POWER_O    <= ctrl0.core_on && next_busy;
         // runs while armed too, else no trigger is ever seen
         OSC_ENABLE_O    <= (ctrl1.clock_source_select
                             == sar_pkg::SRC_OSC) && ctrl0.core_on
                            && (next_busy || ctrl0.conversion_enable);
         BANDGAP_ON_O    <= ctrl0.reference_on;
         REF_BUFFER_ON_O <= ctrl0.reference_on
                            && (next_busy || (ctrl0.reference_output
                            && !ctrl0.reference_burst));
         REF_PIN_OUT_O   <= ctrl0.reference_on
                            && ctrl0.reference_output;
         EXT_REF_BUFFER_O <= (ctrl0.reference_select
                              == sar_pkg::REF_EXT_BUF) && next_busy;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks

   logic [6:0] samp_h; // ticks seen while sampling
   logic [6:0] conv_h; // ticks seen while converting

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I || !SAMPLE_ACTIVE_O)
         samp_h <= 7'h00;
      else
         samp_h <= samp_h + {6'h00, conv_tick};
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RESET_I || state != sar_pkg::ST_CONVERT)
         conv_h <= 7'h00;
      else
         conv_h <= conv_h + {6'h00, conv_tick};
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);

   a_start_needs_enable: assert property (
      $rose(SAMPLE_ACTIVE_O) |-> $past(ctrl0.conversion_enable && ctrl0.core_on))
      else $error("operation started while disabled");
   // a restart would show as a fresh sample phase at count zero
   a_no_restart: assert property (
      (state != sar_pkg::ST_IDLE && conv_tick && trig_edge)
      |=> (state == sar_pkg::ST_IDLE || phase_cnt != 7'h00
           || ($past(state) == sar_pkg::ST_SAMPLE && state == sar_pkg::ST_CONVERT)))
      else $error("running operation restarted");
   a_sample_len: assert property (
      $fell(SAMPLE_ACTIVE_O)
      |-> samp_h == hold_ticks(ctrl0.sample_hold_time))
      else $error("sample window length wrong");
   a_conv_len: assert property (
      $fell(state == sar_pkg::ST_CONVERT) |-> conv_h == sar_pkg::CONV_TICKS)
      else $error("conversion not 13 ticks");
   a_result_flag: assert property (
      (state == sar_pkg::ST_CONVERT && next_state == sar_pkg::ST_IDLE)
      |=> result_new ##0 !$stable(conv_h))
      else $error("result not flagged at end");
   a_core_auto: assert property (
      CORE_POWER_O |-> state != sar_pkg::ST_IDLE)
      else $error("core powered while idle");
   a_burst_buffer: assert property (
      REF_BUFFER_ON_O && $past(ctrl0.reference_burst)
      |-> state != sar_pkg::ST_IDLE)
      else $error("burst buffer on while idle");
   a_ctrl1_lock: assert property (
      (wr && PADDR_I == sar_pkg::OFF_CTRL1 && ctrl0.conversion_enable)
      |=> $stable(ctrl1))
      else $error("locked control changed");
   a_full_scale: assert property (
      (next_state == sar_pkg::ST_IDLE && state == sar_pkg::ST_CONVERT
       && trial == sar_pkg::FULL_SCALE && !ctrl1.twos_complement)
      |=> conversion_result == sar_pkg::FULL_SCALE)
      else $error("full scale code wrong");

   c_sample_to_convert: cover property (
      $fell(SAMPLE_ACTIVE_O) ##1 state == sar_pkg::ST_CONVERT);
   c_result_done: cover property ($rose(result_new));
   c_signed_result: cover property (
      $rose(result_new) && ctrl1.twos_complement);

endmodule

`default_nettype wire

// file: verilog/sar_pkg.sv
`default_nettype none

package sar_pkg;

   // register byte offsets
   localparam logic [11:0] OFF_CTRL0  = 12'h000;
   localparam logic [11:0] OFF_CTRL1  = 12'h004;
   localparam logic [11:0] OFF_AEN    = 12'h008;
   localparam logic [11:0] OFF_RESULT = 12'h00C;
   localparam logic [11:0] OFF_STATUS = 12'h010;

   // control field layouts, lsb last
   typedef struct packed {
      logic [1:0] sample_hold_time;
      logic [1:0] reference_select;
      logic       buffer_speed_select;
      logic       reference_burst;
      logic       reference_output;
      logic       reference_level_select;
      logic       reference_on;
      logic       core_on;
      logic       software_start;
      logic       conversion_enable;
   } ctrl0_type;

   typedef struct packed {
      logic       twos_complement;
      logic [2:0] clock_divider;
      logic [1:0] clock_source_select;
      logic       trigger_invert;
      logic [1:0] trigger_source_select;
      logic [3:0] channel;
   } ctrl1_type;

   // reset values
   localparam ctrl0_type CTRL0_RESET = 12'h000;
   localparam ctrl1_type CTRL1_RESET = 13'h0000;
   localparam logic [7:0] AEN_RESET  = 8'h00;

   // converter figures
   localparam logic [9:0] FULL_SCALE  = 10'h3FF;
   localparam logic [9:0] SIGN_FLIP   = 10'h200;
   localparam logic [6:0] CONV_TICKS  = 7'h0D;
   localparam logic [6:0] SAR_STEPS   = 7'h0A;
   localparam logic [3:0] CHAN_LAST   = 4'hB;
   localparam logic [6:0] HOLD_SHORT  = 7'h04;
   localparam logic [6:0] HOLD_MID    = 7'h08;
   localparam logic [6:0] HOLD_LONG   = 7'h10;
   localparam logic [6:0] HOLD_MAX    = 7'h40;
   localparam logic [1:0] SRC_OSC     = 2'h3;
   localparam logic [1:0] REF_EXT_BUF = 2'h3;

   // synchroniser slots
   localparam int IN_TIMER1 = 5;
   localparam int IN_TIMER0 = 6;
   localparam int IN_TIMER2 = 7;
   localparam int IN_COMP   = 8;

   // operation states, gray along idle-sample-convert
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b11
   } state_type;

endpackage

`default_nettype wire

// file: verif/sar_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////
module sar_analog_model (
   // analog side
   input  wire logic [10:0] level_i,
   input  wire logic [9:0]  code_i,
   output logic             compare_o,
   // clock sources: subsys, master, aux, osc
   output logic [3:0]       source_clk_o
);
   // input sits half a step above level, so the code settles on it
   assign compare_o = (level_i >= {1'b0, code_i});

   initial source_clk_o = 4'h0;
   // sources run free, never stopped mid-conversion
   for (genvar i = 0; i < 4; i++)
   begin : g_src
      always #(50 + 10 * i) source_clk_o[i] = ~source_clk_o[i];
   end
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

////////////////////////////////////////////////////////////////
module tb;
   logic        clk = 1'b0;               // system clock
   logic        rst = 1'b1;               // sync reset
   logic        psel = 1'b0;              // apb request
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, q;                   // read data
   logic        prdy, perr, e;
   logic [2:0]  tmr = 3'h0;               // timer trigger pins
   logic [10:0] lvl = 11'h000;            // analog level
   logic [3:0]  src_clk;
   logic [9:0]  dac;
   logic [3:0]  chan;
   logic [7:0]  aen;
   logic        cmp, samp, core_pw, osc_en, bg, rbuf, rlvl, rpin, xbuf, slow;
   int          err_total = 0;
   int          num_checks = 0;
   int          n;

   always #5 clk = ~clk;

   sar_converter_control uut (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
      .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
      .SUBSYS_CLK_I(src_clk[0]), .MASTER_CLK_I(src_clk[1]),
      .AUX_CLK_I(src_clk[2]), .OSC_CLK_I(src_clk[3]), .TIMER_OUT0_I(tmr[0]),
      .TIMER_OUT1_I(tmr[1]), .TIMER_OUT2_I(tmr[2]), .COMPARE_I(cmp),
      .DAC_CODE_O(dac), .CHANNEL_O(chan), .PIN_ANALOG_EN_O(aen),
      .SAMPLE_ACTIVE_O(samp), .CORE_POWER_O(core_pw), .OSC_ENABLE_O(osc_en),
      .BANDGAP_ON_O(bg), .REF_BUFFER_ON_O(rbuf), .REF_LEVEL_O(rlvl),
      .REF_PIN_OUT_O(rpin), .EXT_REF_BUFFER_O(xbuf), .BUFFER_SLOW_O(slow));

   sar_analog_model far (.level_i(lvl), .code_i(dac), .compare_o(cmp),
      .source_clk_o(src_clk));

   ////////////////////////////////////////////////////////////////
   // verdict, reached from the end of the run or a spent wait
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one apb transfer; an idle cycle follows so psel is never re-raised in one step
   task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (prdy !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         err_total++;
         complete_run();
      end
      q = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   // edges until sample window (0) or core power (1) shows v
   task automatic waitsig(input logic which, input logic v, output int k);
      logic s;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
         s = which ? core_pw : samp;
      end
      while (s !== v && k < 20000);
      if (k >= 20000)
      begin
         err_total++;
         complete_run();
      end
   endtask

   // one triggered sample and conversion with full config
   task automatic conv(input logic [1:0] src, input logic inv, input logic [1:0] sht,
      input logic [2:0] dv, input logic [1:0] cs, input logic tw,
      input logic [10:0] l, input logic [11:0] ex);
      int          p, hold, idx;
      logic [31:0] c1;
      logic [9:0]  r;
      p = (10 + 2 * cs) * (dv + 1);
      hold = (sht == 2'h3) ? 64 : (4 << sht);
      idx = (src == 2'h2) ? 0 : ((src == 2'h1) ? 1 : 2);
      c1 = {19'h0, tw, dv, cs, inv, src, 4'h3};
      lvl <= l;
      tmr <= {3{inv}};
      ap(1'b1, sar_pkg::OFF_CTRL0, 32'h0);
      ap(1'b1, sar_pkg::OFF_CTRL1, c1);
      // old trigger level must drain out of the tick stages first
      repeat (4 * p) @(posedge clk);
      ap(1'b1, sar_pkg::OFF_CTRL0, {20'h0, sht, 10'h005} | ex);
      repeat (40) @(posedge clk);
      if (src == 2'h0)
         ap(1'b1, sar_pkg::OFF_CTRL0, 32'h3);
      else
         tmr[idx] <= ~inv;
      waitsig(1'b0, 1'b1, n);
      `CHK(core_pw, 1'b1)
      `CHK(rbuf, ex[3])
      `CHK(xbuf, &ex[9:8])
      `CHK(osc_en, cs == 2'h3)
      // a second edge inside the window must not restart
      tmr[idx] <= inv;
      repeat (p) @(posedge clk);
      tmr[idx] <= ~inv;
      waitsig(1'b0, 1'b0, n);
      `CHK((n + p >= hold * p - 1) && (n + p <= hold * p + 1), 1'b1)
      waitsig(1'b1, 1'b0, n);
      `CHK((n >= 13 * p - 1) && (n <= 13 * p + 2), 1'b1)
      repeat (4 * p) @(posedge clk);
      ap(1'b0, sar_pkg::OFF_STATUS, 32'h0);
      `CHK(q, 32'h4)
      r = (l > 11'h3FF) ? 10'h3FF : l[9:0];
      ap(1'b0, sar_pkg::OFF_RESULT, 32'h0);
      `CHK(q, {22'h0, tw ? r ^ 10'h200 : r})
      ap(1'b1, sar_pkg::OFF_CTRL1, 32'h0);
      ap(1'b0, sar_pkg::OFF_CTRL1, 32'h0);
      `CHK(q, c1)
      `CHK({bg, rlvl, rpin, slow, xbuf}, {ex[3], ex[4], ex[3] & ex[5], ex[7], 1'b0})
      `CHK(rbuf, ex[3] & ex[5] & ~ex[6])
      ap(1'b1, sar_pkg::OFF_CTRL0, 32'h0);
      repeat (3) @(posedge clk);
      `CHK({osc_en, core_pw}, 2'b00)
   endtask

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values and the unmapped slot
      for (int i = 0; i < 4; i++)
      begin
         ap(1'b0, (i == 3) ? 12'h014 : 12'(i * 4), 32'h0);
         `CHK({q, e}, {32'h0, i == 3})
      end
      ap(1'b1, sar_pkg::OFF_AEN, 32'hA5);
      `CHK(aen, 8'hA5)
      for (int c = 0; c < 16; c++)
      begin
         ap(1'b1, sar_pkg::OFF_CTRL1, 32'(c));
         `CHK(chan, (c > 11) ? 4'hB : 4'(c))
      end
      // start attempts lacking enable, then lacking core_on
      for (int i = 0; i < 2; i++)
      begin
         ap(1'b1, sar_pkg::OFF_CTRL0, (i == 0) ? 32'h6 : 32'h3);
         repeat (200) @(posedge clk);
         `CHK(samp, 1'b0)
         ap(1'b0, sar_pkg::OFF_STATUS, 32'h0);
         `CHK(q, 32'h0)
      end
      conv(2'h0, 1'b0, 2'h0, 3'h0, 2'h3, 1'b0, 11'h7FF, 12'h000);
      conv(2'h1, 1'b0, 2'h1, 3'h1, 2'h0, 1'b0, 11'h000, 12'h028);
      conv(2'h2, 1'b1, 2'h2, 3'h7, 2'h1, 1'b1, 11'h155, 12'h3F8);
      conv(2'h3, 1'b1, 2'h3, 3'h2, 2'h2, 1'b0, 11'h2AA, 12'h000);
      complete_run();
   end
endmodule
`default_nettype wire
